// File: core/uart_fifo_block.sv
// Purpose: UART receive and transmit FIFOs, polled status and delayed transmit-empty interrupt
// Assumes: Shifters and framing run on clk; AXI4-Lite master keeps one read and one write open
// Notes:   Serial-side strobes are same-domain, so they are not synchronised
//
// Contract
// - Cleared enables put each direction in polled mode
// - Data-ready bit set while receive FIFO nonempty
// - Status bits 1-4 report overrun and character errors
// - Line errors leave identification alone when disabled
// - Bit 5 set while transmit FIFO empty
// - Bit 6 set when FIFO and shifter empty
// - Bit 7 set while any stored character errored
// - Polled mode hides trigger, FIFOs still full-size
// - Separate sixteen-byte transmit and receive FIFOs
// - Receive threshold selectable as 1, 4, 8, 14
// - Receive FIFO fills to sixteen past threshold
// - Transmit starts once a byte is queued
// - Full transmit FIFO blocks host writes
// - Transmit interrupt when empty and enabled
// - First byte drops transmit-empty interrupt at once
// - Re-empty waits one character less stop bit before interrupt
// - Delay holds until two bytes coexist
// - Full receive FIFO drops data, sets overrun
// - Delay equals character minus stop bit
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps

module byte_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       clr,
    input  wire logic                       in_valid,
    output logic                            in_ready,
    input  wire logic [WIDTH-1:0]           in_data,
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic [WIDTH-1:0]                out_data,
    output logic [$clog2(DEPTH+1)-1:0]      count
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam int unsigned CW = $clog2(DEPTH+1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [CW-1:0]               cnt;
    } fifo_st_t;

    fifo_st_t st_r;
    fifo_st_t st_nxt;
    logic     push;
    logic     pop;

    assign in_ready  = (st_r.cnt != CW'(DEPTH));
    assign out_valid = (st_r.cnt != '0);
    assign out_data  = st_r.mem[st_r.rp];
    assign count     = st_r.cnt;

    always_comb begin
        push   = in_valid && in_ready;
        pop    = out_valid && out_ready;
        st_nxt = st_r;
        if (clr) begin
            st_nxt.wp  = '0;
            st_nxt.rp  = '0;
            st_nxt.cnt = '0;
        end else begin
            if (push) begin
                st_nxt.mem[st_r.wp] = in_data;
                st_nxt.wp           = st_r.wp + 1'b1;
            end
            if (pop) begin
                st_nxt.rp = st_r.rp + 1'b1;
            end
            if (push && !pop) begin
                st_nxt.cnt = st_r.cnt + 1'b1;
            end else if (pop && !push) begin
                st_nxt.cnt = st_r.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule : byte_fifo

module uart_fifo_block #(
    parameter int unsigned DEPTH        = uart_fifo_pkg::FIFO_DEPTH,
    parameter int unsigned TX_DELAY_CYC = uart_fifo_pkg::TX_DELAY_CYC
) (
    input  wire logic                              clk,
    input  wire logic                              rst,
    input  wire logic [uart_fifo_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                              s_axi_awvalid,
    output logic                                   s_axi_awready,
    input  wire logic [31:0]                       s_axi_wdata,
    input  wire logic [3:0]                        s_axi_wstrb,
    input  wire logic                              s_axi_wvalid,
    output logic                                   s_axi_wready,
    output logic [1:0]                             s_axi_bresp,
    output logic                                   s_axi_bvalid,
    input  wire logic                              s_axi_bready,
    input  wire logic [uart_fifo_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                              s_axi_arvalid,
    output logic                                   s_axi_arready,
    output logic [31:0]                            s_axi_rdata,
    output logic [1:0]                             s_axi_rresp,
    output logic                                   s_axi_rvalid,
    input  wire logic                              s_axi_rready,
    output logic [uart_fifo_pkg::DATA_W-1:0]       tx_data,
    output logic                                   tx_valid,
    input  wire logic                              tx_load,
    input  wire logic                              tx_busy,
    input  wire logic [uart_fifo_pkg::DATA_W-1:0]  rx_data,
    input  wire logic [uart_fifo_pkg::ERR_W-1:0]   rx_err,
    input  wire logic                              rx_valid,
    output logic                                   irq
);
    import uart_fifo_pkg::*;

    localparam int unsigned CW  = $clog2(DEPTH+1);
    localparam int unsigned DCW = $clog2(TX_DELAY_CYC+1);
    localparam int unsigned RW  = DATA_W + ERR_W;

    typedef struct packed {
        logic              aw_have;
        logic [ADDR_W-1:0] awaddr;
        logic              w_have;
        logic [7:0]        wbyte;
        logic              wen;
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic [3:0]        ier;
        logic              fifo_en;
        logic [1:0]        trig_sel;
        logic [3:0]        lerr;
        logic [CW-1:0]     err_cnt;
        logic              head_new;
        logic              multi;
        logic [DCW-1:0]    dly;
        logic              thre_ack;
        logic              tx_empty_q;
        logic              irq;
    } blk_st_t;

    blk_st_t st_r;
    blk_st_t st_nxt;

    logic              tx_in_ready;
    logic [CW-1:0]     tx_cnt;
    logic              rx_in_ready;
    logic              rx_out_valid;
    logic [RW-1:0]     rx_out;
    logic [CW-1:0]     rx_cnt;
    logic              wr_go;
    logic              rd_go;
    logic              tx_push;
    logic              rx_pop;
    logic              rx_take;
    logic              tx_clr;
    logic              rx_clr;
    logic              en_change;
    logic              tx_empty;
    logic              became_empty;
    logic              dly_arm;
    logic              thre_pend;
    logic [7:0]        lsr_w;
    logic [7:0]        iir_w;

    function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
        unique case ({a[ADDR_W-1:2], 2'b00})
            OFS_DATA: reg_sel = 3'h1;
            OFS_IER:  reg_sel = 3'h2;
            OFS_FCR:  reg_sel = 3'h3;
            OFS_IIR:  reg_sel = 3'h4;
            OFS_LSR:  reg_sel = 3'h5;
            default:  reg_sel = 3'h0;
        endcase
    endfunction : reg_sel

    function automatic logic [CW-1:0] trig_level(input logic [1:0] sel);
        unique case (sel)
            2'h0: trig_level = CW'(TRIG_1);
            2'h1: trig_level = CW'(TRIG_4);
            2'h2: trig_level = CW'(TRIG_8);
            2'h3: trig_level = CW'(TRIG_14);
        endcase
    endfunction : trig_level

    // Two independent FIFOs of full depth regardless of threshold
    byte_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_tx_fifo (
        .clk       (clk),
        .rst       (rst),
        .clr       (tx_clr),
        .in_valid  (tx_push),
        .in_ready  (tx_in_ready),
        .in_data   (st_r.wbyte),
        .out_valid (tx_valid),
        .out_ready (tx_load),
        .out_data  (tx_data),
        .count     (tx_cnt)
    );

    byte_fifo #(.WIDTH(RW), .DEPTH(DEPTH)) u_rx_fifo (
        .clk       (clk),
        .rst       (rst),
        .clr       (rx_clr),
        .in_valid  (rx_valid),
        .in_ready  (rx_in_ready),
        .in_data   ({rx_err, rx_data}),
        .out_valid (rx_out_valid),
        .out_ready (rx_pop),
        .out_data  (rx_out),
        .count     (rx_cnt)
    );

    always_comb begin
        st_nxt    = st_r;
        wr_go     = st_r.aw_have && st_r.w_have && !st_r.bvalid;
        rd_go     = s_axi_arvalid && st_r.arready;
        // Host write into a full FIFO is simply not stored
        tx_push   = wr_go && st_r.wen && (reg_sel(st_r.awaddr) == 3'h1) && tx_in_ready;
        rx_pop    = rd_go && (reg_sel(s_axi_araddr) == 3'h1) && rx_out_valid;
        rx_take   = rx_valid && rx_in_ready;
        en_change = wr_go && st_r.wen && (reg_sel(st_r.awaddr) == 3'h3)
                    && (st_r.wbyte[FCR_EN_BIT] != st_r.fifo_en);
        tx_clr    = en_change || (wr_go && st_r.wen && (reg_sel(st_r.awaddr) == 3'h3)
                    && st_r.wbyte[FCR_TXCLR_BIT]);
        rx_clr    = en_change || (wr_go && st_r.wen && (reg_sel(st_r.awaddr) == 3'h3)
                    && st_r.wbyte[FCR_RXCLR_BIT]);
        tx_empty  = (tx_cnt == '0);
        became_empty = tx_empty && !st_r.tx_empty_q && !tx_clr;
        dly_arm   = became_empty && !st_r.multi && st_r.fifo_en;
        // Arming cycle masked too, else a one-cycle pulse escapes
        thre_pend = tx_empty && (st_r.dly == '0) && !st_r.thre_ack && !dly_arm;

        lsr_w = '0;
        lsr_w[LSR_DR_BIT]   = rx_out_valid;
        lsr_w[4:1]          = st_r.lerr;
        lsr_w[LSR_THRE_BIT] = tx_empty;
        lsr_w[LSR_TEMT_BIT] = tx_empty && !tx_busy;
        lsr_w[LSR_FERR_BIT] = (st_r.err_cnt != '0);

        // Priority: line status, then receive data, then transmit empty
        iir_w = {st_r.fifo_en, st_r.fifo_en, 2'b00, IIR_NONE};
        if (st_r.ier[IER_LS_BIT] && (st_r.lerr != '0)) begin
            iir_w[3:0] = IIR_LINE;
        end else if (st_r.ier[IER_RX_BIT] && (st_r.fifo_en ? (rx_cnt >= trig_level(st_r.trig_sel))
                                                          : rx_out_valid)) begin
            iir_w[3:0] = IIR_RXD;
        end else if (st_r.ier[IER_TX_BIT] && thre_pend) begin
            iir_w[3:0] = IIR_THRE;
        end
        st_nxt.irq = !iir_w[0];

        // Write address and data are taken independently
        if (s_axi_awvalid && st_r.awready) begin
            st_nxt.aw_have = 1'b1;
            st_nxt.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_r.wready) begin
            st_nxt.w_have = 1'b1;
            st_nxt.wbyte  = s_axi_wdata[7:0];
            st_nxt.wen    = s_axi_wstrb[0];
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (wr_go) begin
            st_nxt.aw_have = 1'b0;
            st_nxt.w_have  = 1'b0;
            st_nxt.bvalid  = 1'b1;
            st_nxt.bresp   = (reg_sel(st_r.awaddr) == 3'h0) ? RESP_SLVERR : RESP_OKAY;
            if (st_r.wen && (reg_sel(st_r.awaddr) == 3'h2)) begin
                st_nxt.ier = st_r.wbyte[3:0];
            end
            if (st_r.wen && (reg_sel(st_r.awaddr) == 3'h3)) begin
                st_nxt.fifo_en  = st_r.wbyte[FCR_EN_BIT];
                st_nxt.trig_sel = st_r.wbyte[FCR_TRG_LSB +: 2];
            end
        end

        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (rd_go) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp  = RESP_OKAY;
            st_nxt.rdata  = '0;
            unique case (reg_sel(s_axi_araddr))
                3'h1: st_nxt.rdata[7:0] = rx_out_valid ? rx_out[DATA_W-1:0] : 8'h00;
                3'h2: st_nxt.rdata[3:0] = st_r.ier;
                3'h3: st_nxt.rdata[7:0] = {st_r.trig_sel, 5'h00, st_r.fifo_en};
                3'h4: st_nxt.rdata[7:0] = iir_w;
                3'h5: st_nxt.rdata[7:0] = lsr_w;
                default: st_nxt.rresp   = RESP_SLVERR;
            endcase
        end
        st_nxt.awready = !st_nxt.aw_have && !st_nxt.bvalid;
        st_nxt.wready  = !st_nxt.w_have && !st_nxt.bvalid;
        st_nxt.arready = !st_nxt.rvalid;

        // Error bits are sticky until a status read; a new error wins over the clear
        if (rd_go && (reg_sel(s_axi_araddr) == 3'h5)) begin
            st_nxt.lerr = '0;
        end
        if (rx_valid && !rx_in_ready) begin
            st_nxt.lerr[0] = 1'b1;
        end
        // Latched once per head character, so a status read clears it for good
        if (st_r.head_new && rx_out_valid) begin
            st_nxt.lerr[3:1] = st_nxt.lerr[3:1] | rx_out[RW-1:DATA_W];
        end
        st_nxt.head_new = !rx_clr && (rx_out_valid ? (rx_pop && ((rx_cnt > CW'(1)) || rx_take)) : rx_take);
        // Running count of stored characters carrying an error
        if (rx_clr) begin
            st_nxt.err_cnt = '0;
        end else begin
            st_nxt.err_cnt = st_r.err_cnt + CW'(rx_take && (rx_err != '0))
                             - CW'(rx_pop && (rx_out[RW-1:DATA_W] != '0));
        end

        // Transmit-empty delay: armed when the FIFO re-empties without ever holding two
        st_nxt.tx_empty_q = tx_empty;
        st_nxt.multi      = (tx_cnt >= CW'(2)) || (st_r.multi && !tx_empty);
        if (en_change) begin
            st_nxt.dly = '0;
        end else if (dly_arm) begin
            st_nxt.dly = DCW'(TX_DELAY_CYC);
        end else if (st_r.dly != '0) begin
            st_nxt.dly = st_r.dly - 1'b1;
        end
        st_nxt.thre_ack = (st_r.thre_ack && !tx_push)
                          || (rd_go && (reg_sel(s_axi_araddr) == 3'h4) && (iir_w[3:0] == IIR_THRE));
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r          <= '0;
            st_r.ier      <= IER_RESET;
            st_r.fifo_en  <= FCR_EN_RESET;
            st_r.trig_sel <= FCR_TRG_RESET;
            st_r.tx_empty_q <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign s_axi_awready = st_r.awready;
    assign s_axi_wready  = st_r.wready;
    assign s_axi_bvalid  = st_r.bvalid;
    assign s_axi_bresp   = st_r.bresp;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rvalid  = st_r.rvalid;
    assign s_axi_rdata   = st_r.rdata;
    assign s_axi_rresp   = st_r.rresp;
    assign irq           = st_r.irq;

    property p_dr_after_push;
        @(posedge clk) disable iff (rst) rx_take && (rx_cnt == '0) && !rx_clr |=> lsr_w[LSR_DR_BIT];
    endproperty
    a_dr_after_push: assert property (p_dr_after_push) else $error("data ready missing");

    property p_tx_full_block;
        @(posedge clk) disable iff (rst) (tx_cnt == CW'(DEPTH)) && !tx_load && !tx_clr |=> tx_cnt == CW'(DEPTH);
    endproperty
    a_tx_full_block: assert property (p_tx_full_block) else $error("full fifo accepted");

    property p_overrun;
        @(posedge clk) disable iff (rst) rx_valid && (rx_cnt == CW'(DEPTH)) && !rx_pop && !rx_clr
            |=> lsr_w[LSR_OE_BIT] && (rx_cnt == CW'(DEPTH));
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged");

    property p_temt;
        @(posedge clk) disable iff (rst) lsr_w[LSR_TEMT_BIT] |-> lsr_w[LSR_THRE_BIT] && !tx_busy && !tx_valid;
    endproperty
    a_temt: assert property (p_temt) else $error("idle flag wrong");

    property p_first_load;
        @(posedge clk) disable iff (rst) tx_push && tx_empty && !tx_load |=> !thre_pend && !lsr_w[LSR_THRE_BIT];
    endproperty
    a_first_load: assert property (p_first_load) else $error("empty irq not dropped");

    property p_delay_start;
        @(posedge clk) disable iff (rst) became_empty && !st_r.multi && st_r.fifo_en && !en_change
            |-> !thre_pend ##1 ((st_r.dly == DCW'(TX_DELAY_CYC)) && !thre_pend);
    endproperty
    a_delay_start: assert property (p_delay_start) else $error("delay not started");

    property p_no_delay_multi;
        @(posedge clk) disable iff (rst) became_empty && st_r.multi |=> st_r.dly == $past(st_r.dly) - ($past(st_r.dly) != '0);
    endproperty
    a_no_delay_multi: assert property (p_no_delay_multi) else $error("delay after two bytes");

    property p_line_masked;
        @(posedge clk) disable iff (rst) !st_r.ier[IER_LS_BIT] |-> iir_w[3:0] != IIR_LINE;
    endproperty
    a_line_masked: assert property (p_line_masked) else $error("line status not masked");

    property p_polled_rx;
        @(posedge clk) disable iff (rst) st_r.fifo_en && !st_r.ier[IER_RX_BIT] |-> iir_w[3:0] != IIR_RXD;
    endproperty
    a_polled_rx: assert property (p_polled_rx) else $error("trigger shown in polled mode");

    property p_trigger;
        @(posedge clk) disable iff (rst) st_r.fifo_en && st_r.ier[IER_RX_BIT] && (st_r.lerr == '0)
            && (rx_cnt >= trig_level(st_r.trig_sel)) |=> irq;
    endproperty
    a_trigger: assert property (p_trigger) else $error("trigger interrupt missing");
endmodule : uart_fifo_block

// File: core/uart_fifo_pkg.sv
// Purpose: Shared constants for the UART FIFO, line status and transmit-empty block
// Assumes: 200 MHz system clock, 32-bit AXI4-Lite register access
// Notes:   Character timing figures are plain defaults; real baud timing lives elsewhere
package uart_fifo_pkg;
    localparam int unsigned FIFO_DEPTH   = 16;
    localparam int unsigned DATA_W       = 8;
    localparam int unsigned ERR_W        = 3;
    localparam int unsigned ADDR_W       = 8;

    localparam logic [ADDR_W-1:0] OFS_DATA = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_IER  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_FCR  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IIR  = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_LSR  = 8'h10;

    localparam logic [3:0] IER_RESET     = 4'h0;
    localparam logic       FCR_EN_RESET  = 1'b0;
    localparam logic [1:0] FCR_TRG_RESET = 2'h0;

    localparam int unsigned FCR_EN_BIT   = 0;
    localparam int unsigned FCR_RXCLR_BIT = 1;
    localparam int unsigned FCR_TXCLR_BIT = 2;
    localparam int unsigned FCR_TRG_LSB  = 6;

    localparam int unsigned IER_RX_BIT   = 0;
    localparam int unsigned IER_TX_BIT   = 1;
    localparam int unsigned IER_LS_BIT   = 2;

    localparam int unsigned LSR_DR_BIT   = 0;
    localparam int unsigned LSR_OE_BIT   = 1;
    localparam int unsigned LSR_THRE_BIT = 5;
    localparam int unsigned LSR_TEMT_BIT = 6;
    localparam int unsigned LSR_FERR_BIT = 7;

    localparam logic [3:0] IIR_NONE = 4'h1;
    localparam logic [3:0] IIR_LINE = 4'h6;
    localparam logic [3:0] IIR_RXD  = 4'h4;
    localparam logic [3:0] IIR_THRE = 4'h2;

    localparam logic [4:0] TRIG_1  = 5'h01;
    localparam logic [4:0] TRIG_4  = 5'h04;
    localparam logic [4:0] TRIG_8  = 5'h08;
    localparam logic [4:0] TRIG_14 = 5'h0e;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned CHAR_TIME_NS  = 50000;
    localparam int unsigned STOP_TIME_NS  = 5000;
    localparam int unsigned TX_DELAY_CYC  = ((CHAR_TIME_NS - STOP_TIME_NS) * 1000) / CLK_PERIOD_PS;
endpackage : uart_fifo_pkg

// File: test/shifter_model.sv
// Purpose: Transmit shift register stand-in on the serial side of the FIFO block
// Assumes: One load pulse per character, busy for CHAR_CYC cycles after it
// Notes:   Stall input holds the shifter off so the bench can fill the FIFO
`timescale 1ns/1ps
module shifter_model #(
    parameter int unsigned CHAR_CYC = 40
) (
    input  wire logic                             clk,
    input  wire logic                             rst,
    input  wire logic                             stall,
    input  wire logic [uart_fifo_pkg::DATA_W-1:0] tx_data,
    input  wire logic                             tx_valid,
    output logic                                  tx_load,
    output logic                                  tx_busy,
    output int                                    sent_cnt,
    output logic [uart_fifo_pkg::DATA_W-1:0]      last_byte
);
    import uart_fifo_pkg::*;
    int left;
    always @(posedge clk) begin
        if (rst) begin
            left      <= 0;
            tx_load   <= 1'b0;
            tx_busy   <= 1'b0;
            sent_cnt  <= 0;
            last_byte <= 8'h00;
        end else if (left > 0) begin
            left    <= left - 1;
            tx_load <= 1'b0;
            tx_busy <= (left > 1);
        end else if (tx_valid && !stall && !tx_load) begin
            // Takes head byte at once, shifting starts with it
            tx_load   <= 1'b1;
            last_byte <= tx_data;
            sent_cnt  <= sent_cnt + 1;
            left      <= CHAR_CYC;
            tx_busy   <= 1'b1;
        end else begin
            tx_load <= 1'b0;
        end
    end
endmodule : shifter_model

// File: test/tb.sv
// Purpose: Register-level bench for the UART FIFO block
// Assumes: Shifter model on transmit side, bench injects received characters
// Notes:   Short transmit delay keeps the run brief
`timescale 1ns/1ps
module tb;
    import uart_fifo_pkg::*;
    localparam int unsigned DLY = 20;
    logic        clk = 0, rst = 1, stall = 1;
    logic [7:0]  awaddr = 0, araddr = 0, rx_data = 0, tx_data, last_byte;
    logic [31:0] wdata = 0, rdata;
    logic [3:0]  wstrb = 4'hf;
    logic [2:0]  rx_err = 0;
    logic [1:0]  bresp, rresp;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, rx_valid = 0;
    logic        awready, wready, bvalid, arready, rvalid, tx_valid, tx_load, tx_busy, irq;
    int          sent_cnt, miscompares = 0, check_count = 0;
    always #2.5 clk = ~clk;
    uart_fifo_block #(.DEPTH(FIFO_DEPTH), .TX_DELAY_CYC(DLY)) i_uart_fifo_block (
        .clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_load(tx_load), .tx_busy(tx_busy), .rx_data(rx_data), .rx_err(rx_err), .rx_valid(rx_valid), .irq(irq));
    shifter_model #(.CHAR_CYC(40)) i_shifter_model (
        .clk(clk), .rst(rst), .stall(stall), .tx_data(tx_data), .tx_valid(tx_valid), .tx_load(tx_load),
        .tx_busy(tx_busy), .sent_cnt(sent_cnt), .last_byte(last_byte));

    task automatic give_verdict;
        if (miscompares == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask : chk
    // Any exhausted wait ends the run as a failure
    task automatic hang;
        chk("wait_done", 1, 0);
        give_verdict;
    endtask : hang
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
        int n;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= {24'h0, d};
        awvalid <= 1;
        wvalid  <= 1;
        bready  <= 1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (bvalid) break;
        end
        bready <= 0;
        r = bresp;
        if (n == 100) hang;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1;
        rready  <= 1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (arready) arvalid <= 0;
            if (rvalid) break;
        end
        rready <= 0;
        d = rdata;
        r = rresp;
        if (n == 100) hang;
    endtask : rd
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        logic [1:0] r;
        wr(a, d, r);
        chk("bresp", RESP_OKAY, r);
    endtask : w
    task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(nm, {24'h0, e}, d);
    endtask : rc
    task automatic rx(input logic [7:0] d, input logic [2:0] e);
        @(posedge clk);
        rx_data  <= d;
        rx_err   <= e;
        rx_valid <= 1;
        @(posedge clk);
        rx_valid <= 0;
    endtask : rx
    task automatic wait_irq(input logic e, output int n);
        for (n = 0; n < 200 && irq !== e; n++) @(posedge clk);
        if (n == 200) hang;
    endtask : wait_irq
    task automatic wait_tx(input int lim);
        int n;
        for (n = 0; n < lim && tx_valid !== 0; n++) @(posedge clk);
        if (n == lim) hang;
    endtask : wait_tx

    initial begin
        int          n;
        int          s;
        logic [31:0] d;
        logic [1:0]  r;
        logic [4:0]  lv [4] = '{TRIG_1, TRIG_4, TRIG_8, TRIG_14};
        repeat (20) @(posedge clk);
        rst <= 0;
        rc("lsr_reset", OFS_LSR, 8'h60);
        rc("ier_reset", OFS_IER, 8'h00);
        rd(8'h20, d, r);
        chk("unmapped_rresp", RESP_SLVERR, r);
        chk("unmapped_rdata", 0, d);
        wr(8'h20, 8'h55, r);
        chk("unmapped_bresp", RESP_SLVERR, r);
        w(OFS_FCR, 8'h01);
        for (int i = 0; i < 17; i++) rx(8'h30 + i[7:0], 3'h0);
        rc("lsr_full", OFS_LSR, 8'h63);
        chk("irq_polled", 0, irq);
        for (int i = 0; i < 16; i++) rc("rx_pop", OFS_DATA, 8'h30 + i[7:0]);
        rc("lsr_drained", OFS_LSR, 8'h60);
        rx(8'h5a, 3'h2);
        repeat (2) @(posedge clk);
        chk("irq_err_masked", 0, irq);
        rc("iir_err", OFS_IIR, 8'hc1);
        rc("lsr_err", OFS_LSR, 8'he9);
        rc("rx_err_pop", OFS_DATA, 8'h5a);
        rc("lsr_err_gone", OFS_LSR, 8'h60);
        w(OFS_IER, 8'h01);
        for (int t = 0; t < 4; t++) begin
            w(OFS_FCR, {t[1:0], 6'h01});
            for (int i = 1; i < lv[t]; i++) rx(8'h00, 3'h0);
            repeat (3) @(posedge clk);
            chk("irq_below_trig", 0, irq);
            rx(8'h00, 3'h0);
            repeat (3) @(posedge clk);
            chk("irq_at_trig", 1, irq);
            if (t == 0) rc("iir_rx", OFS_IIR, 8'hc4);
            w(OFS_FCR, {t[1:0], 6'h03});
        end
        rx(8'h77, 3'h0);
        w(OFS_FCR, 8'h01);
        w(OFS_IER, 8'h00);
        repeat (2) @(posedge clk);
        chk("irq_rx_polled", 0, irq);
        rc("rx_last_pop", OFS_DATA, 8'h77);
        w(OFS_IER, 8'h04);
        rx(8'h11, 3'h1);
        repeat (3) @(posedge clk);
        chk("irq_line", 1, irq);
        rc("iir_line", OFS_IIR, 8'hc6);
        rc("lsr_parity", OFS_LSR, 8'he5);
        rc("rx_par_pop", OFS_DATA, 8'h11);
        chk("irq_line_clr", 0, irq);
        w(OFS_IER, 8'h02);
        wait_irq(1, n);
        w(OFS_DATA, 8'ha1);
        repeat (2) @(posedge clk);
        chk("irq_first_byte", 0, irq);
        stall <= 0;
        wait_tx(50);
        wait_irq(1, n);
        chk("tx_delay", 1, n >= DLY - 3 && n <= DLY + 3);
        chk("tx_byte", 8'ha1, last_byte);
        stall <= 1;
        w(OFS_DATA, 8'hb1);
        w(OFS_DATA, 8'hb2);
        stall <= 0;
        wait_tx(100);
        wait_irq(1, n);
        chk("tx_no_delay", 1, n <= 3);
        rc("iir_thre", OFS_IIR, 8'hc2);
        repeat (2) @(posedge clk);
        chk("irq_thre_ack", 0, irq);
        rc("lsr_shifting", OFS_LSR, 8'h20);
        repeat (45) @(posedge clk);
        rc("lsr_idle", OFS_LSR, 8'h60);
        stall <= 1;
        s = sent_cnt;
        for (int i = 0; i < 17; i++) w(OFS_DATA, 8'h10 + i[7:0]);
        rc("lsr_tx_full", OFS_LSR, 8'h00);
        stall <= 0;
        for (n = 0; n < 100 && sent_cnt == s; n++) @(posedge clk);
        if (n == 100) hang;
        stall <= 1;
        w(OFS_DATA, 8'h99);
        stall <= 0;
        wait_tx(2000);
        chk("tx_sent", s + 17, sent_cnt);
        chk("tx_last", 8'h99, last_byte);
        give_verdict;
    end
endmodule : tb
